// [hw/flash_gate_pkg.sv]
// Package for the data flash access and mode gate.
// Assumes one 20-bit CPU address space and byte-wide register access.
package flash_gate_pkg;

  // ==========================================================================
  // Register map
  localparam logic [19:0] DATA_FLASH_ACCESS_CONTROL_ADDR = 20'hF0090;
  localparam logic [19:0] FLASH_PROTECT_COMMAND_REG_ADDR = 20'hF00C0;
  localparam logic [19:0] PROGRAMMING_MODE_CONTROL_REG_ADDR = 20'hF00C1;

  // ==========================================================================
  // Field positions, the reset value and the protect key
  localparam int unsigned ACCESS_ENABLE_BIT = 0;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned SEQ_ERR_BIT = 2;
  localparam logic [7:0] ACCESS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PROTECT_KEY = 8'hA5;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    MODE_NONPROG = 2'b00,
    MODE_CODE_PROG = 2'b01,
    MODE_DATA_PROG = 2'b10
  } prog_mode_t;

  typedef enum logic [1:0] {
    AREA_CODE = 2'b00,
    AREA_DATA = 2'b01,
    AREA_EXTRA = 2'b10
  } flash_area_t;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_ARMED = 1'b1
  } seq_state_t;

  // One CPU register access; bit_op selects a single-bit manipulation.
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [19:0] addr;
    logic [7:0] wdata;
  } cpu_access_t;

  // One flash access request; write means a rewrite (erase or program).
  typedef struct packed {
    logic valid;
    logic write;
    flash_area_t area;
  } flash_req_t;

endpackage

// [hw/flash_mode_ctrl.sv]
// Flash programming mode register with its protected entry sequence.
// Assumes the caller has already merged bit operations into i_wdata.
`timescale 1ns/1ps

module flash_mode_ctrl (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_wr,
  input wire logic [19:0] i_addr,
  input wire logic [7:0] i_wdata,
  output flash_gate_pkg::prog_mode_t o_mode,
  output logic o_seq_err
);

  // ==========================================================================
  // Sequence state
  flash_gate_pkg::seq_state_t state_q, state_d;
  flash_gate_pkg::prog_mode_t mode_q, mode_d;
  logic err_q, err_d;
  logic key_wr;
  logic mode_wr;

  assign key_wr = i_wr && (i_addr == flash_gate_pkg::FLASH_PROTECT_COMMAND_REG_ADDR)
                  && (i_wdata == flash_gate_pkg::PROTECT_KEY);
  assign mode_wr = i_wr && (i_addr == flash_gate_pkg::PROGRAMMING_MODE_CONTROL_REG_ADDR);

  // The key only arms one write; any other write in between disarms it, so a
  // stray store cannot change the mode.
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    err_d = err_q;
    case (state_q)
      flash_gate_pkg::SEQ_IDLE: begin
        if (key_wr) begin
          state_d = flash_gate_pkg::SEQ_ARMED;
        end else if (mode_wr) begin
          err_d = 1'b1; // [RULE_08]
        end
      end
      flash_gate_pkg::SEQ_ARMED: begin
        if (i_wr) begin
          state_d = flash_gate_pkg::SEQ_IDLE;
          if (mode_wr && i_wdata[1:0] != 2'b11) begin
            mode_d = flash_gate_pkg::prog_mode_t'(i_wdata[1:0]); // [RULE_08]
            err_d = 1'b0;
          end else begin
            err_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = flash_gate_pkg::SEQ_IDLE;
      end
    endcase
  end

  // Registers of the sequence.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= flash_gate_pkg::SEQ_IDLE;
      mode_q <= flash_gate_pkg::MODE_NONPROG;
      err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      err_q <= err_d;
    end
  end

  assign o_mode = mode_q;
  assign o_seq_err = err_q;

  // ==========================================================================
  // Checks
  sequence s_armed_mode_write;
    state_q == flash_gate_pkg::SEQ_ARMED && mode_wr;
  endsequence

  a_mode_only_seq: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_08]
    $changed(mode_q) |-> $past(state_q) == flash_gate_pkg::SEQ_ARMED && $past(mode_wr))
    else $error("Mode changed without the protected sequence.");

  a_seq_loads_mode: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_08]
    s_armed_mode_write and (i_wdata[1:0] != 2'b11) |=> mode_q == $past(i_wdata[1:0]))
    else $error("Protected sequence did not load the mode.");

  a_key_arms_once: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_08]
    (state_q == flash_gate_pkg::SEQ_ARMED && i_wr) |=> state_q == flash_gate_pkg::SEQ_IDLE)
    else $error("Key stayed armed past one write.");

endmodule

// [hw/data_flash_access_gate.sv]
// Data flash access control register and flash rewrite gating.
// Assumes CPU accesses arrive one per cycle, synchronous to i_mclk.
`timescale 1ns/1ps

// Behaviour
// [RULE_01] The access control register sits at F0090H, is read/write and resets to 00H.
// [RULE_02] The register accepts both single-bit manipulation and full byte writes.
// [RULE_03] With the enable bit at 0 every data flash access is blocked.
// [RULE_04] With the enable bit at 1 data flash access is allowed; extra area ignores the bit.
// [RULE_05] Code programming mode allows rewrite of the code and extra areas.
// [RULE_06] Data programming mode allows rewrite of the data area only.
// [RULE_07] Non-programmable mode rejects every rewrite of all three areas.
// [RULE_08] The mode changes only via a key write followed by the mode register write.
// [RULE_09] Software sets the enable bit before it touches the data flash area.
// [RULE_10] Bits 7 to 1 of the access control register read as zero and ignore writes.
module data_flash_access_gate (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input flash_gate_pkg::cpu_access_t i_cpu,
  output logic [7:0] o_rdata,
  input flash_gate_pkg::flash_req_t i_flash_req,
  output logic o_flash_grant,
  output logic o_flash_reject,
  output logic o_data_flash_access_enable,
  output flash_gate_pkg::prog_mode_t o_mode
);

  // ==========================================================================
  // Register bus decode
  logic access_enable_q, access_enable_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] merged;
  logic [7:0] cur_val;
  logic seq_err;
  flash_gate_pkg::prog_mode_t mode;

  // Readable value of a register, used for reads and as the base of bit ops.
  function automatic logic [7:0] reg_value(input logic [19:0] addr, input logic en,
                                           input logic [1:0] md, input logic err);
    logic [7:0] v;
    v = 8'h00;
    if (addr == flash_gate_pkg::DATA_FLASH_ACCESS_CONTROL_ADDR) begin
      v[flash_gate_pkg::ACCESS_ENABLE_BIT] = en; // [RULE_10]
    end else if (addr == flash_gate_pkg::PROGRAMMING_MODE_CONTROL_REG_ADDR) begin
      v[flash_gate_pkg::MODE_LSB +: 2] = md;
      v[flash_gate_pkg::SEQ_ERR_BIT] = err;
    end
    return v;
  endfunction

  // A bit operation is a read-modify-write of the addressed byte.
  always_comb begin
    cur_val = reg_value(i_cpu.addr, access_enable_q, mode, seq_err);
    merged = i_cpu.wdata;
    if (i_cpu.bit_op) begin
      merged = cur_val; // [RULE_02]
      merged[i_cpu.bit_idx] = i_cpu.bit_val;
    end
  end

  // Enable bit and registered read data.
  always_comb begin
    access_enable_d = access_enable_q;
    rdata_d = rdata_q;
    if (i_cpu.wr && i_cpu.addr == flash_gate_pkg::DATA_FLASH_ACCESS_CONTROL_ADDR) begin
      access_enable_d = merged[flash_gate_pkg::ACCESS_ENABLE_BIT]; // [RULE_02] [RULE_10]
    end
    if (i_cpu.rd) begin
      rdata_d = cur_val;
    end
  end

  // State registers; read data is registered so the bus sees a clean byte.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      access_enable_q <= flash_gate_pkg::ACCESS_CONTROL_RESET[0]; // [RULE_01]
      rdata_q <= 8'h00;
    end else begin
      access_enable_q <= access_enable_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_data_flash_access_enable = access_enable_q;
  assign o_mode = mode;

  // ==========================================================================
  // Mode register and its protected sequence
  flash_mode_ctrl u_mode (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_wr(i_cpu.wr),
    .i_addr(i_cpu.addr),
    .i_wdata(merged),
    .o_mode(mode),
    .o_seq_err(seq_err)
  );

  // ==========================================================================
  // Flash access gating
  logic allowed;

  // Reads need only the enable bit for the data area; rewrites also need the
  // matching programming mode. Software that skips the enable gets a reject.
  always_comb begin
    allowed = 1'b0;
    if (!i_flash_req.write) begin
      allowed = (i_flash_req.area != flash_gate_pkg::AREA_DATA) || access_enable_q; // [RULE_03] [RULE_04]
    end else begin
      case (mode)
        flash_gate_pkg::MODE_CODE_PROG: begin
          allowed = i_flash_req.area == flash_gate_pkg::AREA_CODE
                    || i_flash_req.area == flash_gate_pkg::AREA_EXTRA; // [RULE_05] [RULE_04]
        end
        flash_gate_pkg::MODE_DATA_PROG: begin
          allowed = i_flash_req.area == flash_gate_pkg::AREA_DATA
                    && access_enable_q; // [RULE_06] [RULE_03] [RULE_09]
        end
        default: begin
          allowed = 1'b0; // [RULE_07]
        end
      endcase
    end
  end

  assign o_flash_grant = i_flash_req.valid && allowed;
  assign o_flash_reject = i_flash_req.valid && !allowed;

  // ==========================================================================
  // Checks
  a_reset_value: assert property (@(posedge i_mclk) // [RULE_01]
    $rose(i_arst_n) |-> !access_enable_q)
    else $error("Access enable not clear after reset.");

  a_byte_write: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_02]
    (i_cpu.wr && !i_cpu.bit_op && i_cpu.addr == flash_gate_pkg::DATA_FLASH_ACCESS_CONTROL_ADDR)
    |=> access_enable_q == $past(i_cpu.wdata[0]))
    else $error("Byte write did not update the enable bit.");

  a_data_blocked: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_03]
    (i_flash_req.valid && i_flash_req.area == flash_gate_pkg::AREA_DATA && !access_enable_q)
    |-> o_flash_reject && !o_flash_grant)
    else $error("Data flash accessed while disabled.");

  a_data_read_ok: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_04]
    (i_flash_req.valid && !i_flash_req.write && access_enable_q) |-> o_flash_grant)
    else $error("Enabled read was refused.");

  a_code_mode: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_05]
    (i_flash_req.valid && i_flash_req.write && mode == flash_gate_pkg::MODE_CODE_PROG)
    |-> o_flash_grant == (i_flash_req.area == flash_gate_pkg::AREA_CODE
                          || i_flash_req.area == flash_gate_pkg::AREA_EXTRA))
    else $error("Code mode rewrite gating wrong.");

  a_data_mode: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_06]
    (i_flash_req.valid && i_flash_req.write && mode == flash_gate_pkg::MODE_DATA_PROG)
    |-> o_flash_grant == (i_flash_req.area == flash_gate_pkg::AREA_DATA && access_enable_q))
    else $error("Data mode rewrite gating wrong.");

  a_nonprog_mode: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_07]
    (i_flash_req.valid && i_flash_req.write && mode == flash_gate_pkg::MODE_NONPROG)
    |-> o_flash_reject)
    else $error("Rewrite granted in non-programmable mode.");

  a_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_10]
    (i_cpu.rd && i_cpu.addr == flash_gate_pkg::DATA_FLASH_ACCESS_CONTROL_ADDR)
    |=> o_rdata[7:1] == 7'h00 && o_rdata[0] == $past(access_enable_q))
    else $error("Access control readback wrong.");

  // Register writes and a disabled data rewrite seen as named steps; a bit write is a read-modify-write of one bit.
  sequence s_enable_bit_write;
    i_cpu.wr && i_cpu.bit_op && i_cpu.bit_idx == 3'h0
    && i_cpu.addr == flash_gate_pkg::DATA_FLASH_ACCESS_CONTROL_ADDR;
  endsequence

  sequence s_upper_bit_write;
    i_cpu.wr && i_cpu.bit_op && i_cpu.bit_idx != 3'h0
    && i_cpu.addr == flash_gate_pkg::DATA_FLASH_ACCESS_CONTROL_ADDR;
  endsequence

  sequence s_foreign_write;
    i_cpu.wr && i_cpu.addr != flash_gate_pkg::DATA_FLASH_ACCESS_CONTROL_ADDR;
  endsequence

  sequence s_disabled_data_rewrite;
    i_flash_req.valid && i_flash_req.write && !access_enable_q
    && i_flash_req.area == flash_gate_pkg::AREA_DATA;
  endsequence

  // A bit write to bit 0 must land exactly like the byte write does.
  a_bit_write: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_02]
    s_enable_bit_write |=> access_enable_q == $past(i_cpu.bit_val))
    else $error("Bit write did not update the enable bit.");

  // Setting a reserved bit by a bit write must not disturb the enable bit.
  a_upper_bits_ignored: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_10]
    s_upper_bit_write |=> $stable(access_enable_q))
    else $error("Reserved bit write changed the enable bit.");

  // Stores elsewhere, the mode sequence included, must leave the enable bit alone.
  a_foreign_keep: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_01]
    s_foreign_write |=> $stable(access_enable_q))
    else $error("Foreign write changed the enable bit.");

  // Read data stands until the next read, so a late poll sees the same byte.
  a_rdata_hold: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_01]
    !i_cpu.rd |=> $stable(o_rdata))
    else $error("Read data changed without a read.");

  // The enable bit gates only the data area; extra area reads pass regardless.
  a_extra_read_free: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_04]
    (i_flash_req.valid && !i_flash_req.write && i_flash_req.area == flash_gate_pkg::AREA_EXTRA)
    |-> o_flash_grant)
    else $error("Extra area read was refused.");

  // A rewrite of the data area needs the enable bit whatever the mode is.
  a_disabled_rewrite: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_03]
    s_disabled_data_rewrite |-> o_flash_reject)
    else $error("Data area rewritten while disabled.");

  // Every valid request gets exactly one answer, and an idle request gets none.
  a_one_answer: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_03]
    i_flash_req.valid |-> o_flash_grant != o_flash_reject)
    else $error("Request answered both or neither way.");

  a_idle_no_answer: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [RULE_03]
    !i_flash_req.valid |-> !o_flash_grant && !o_flash_reject)
    else $error("Answer given without a request.");

endmodule

// [verification/test_data_flash_access_gate.sv]
// Self-checking testbench for the data flash access and mode gate.
// Assumes the gate package and design files are compiled before this file.
`timescale 1ns/1ps

module test_data_flash_access_gate;
  `define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end

  // ==========================================================================
  // Signals and design instance
  logic i_mclk;
  logic i_arst_n;
  flash_gate_pkg::cpu_access_t cpu;
  flash_gate_pkg::flash_req_t req;
  logic [7:0] rdata;
  logic grant;
  logic reject;
  logic en;
  flash_gate_pkg::prog_mode_t mode;
  logic [7:0] rv;
  int n_mismatch = 0;
  int checks_done = 0;
  localparam logic [19:0] DFA = flash_gate_pkg::DATA_FLASH_ACCESS_CONTROL_ADDR;
  localparam logic [19:0] PKA = flash_gate_pkg::FLASH_PROTECT_COMMAND_REG_ADDR;
  localparam logic [19:0] PMA = flash_gate_pkg::PROGRAMMING_MODE_CONTROL_REG_ADDR;

  data_flash_access_gate DUT (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_cpu(cpu),
    .o_rdata(rdata),
    .i_flash_req(req),
    .o_flash_grant(grant),
    .o_flash_reject(reject),
    .o_data_flash_access_enable(en),
    .o_mode(mode)
  );

  // ==========================================================================
  // Clock, 50 ns period.
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // ==========================================================================
  // Bus tasks; each access is one cycle wide and is released at the taking edge.
  // Writes return 1 ns after that edge, so the register they load has settled.
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    cpu <= '{1'b1, 1'b0, 1'b0, 3'h0, 1'b0, a, d};
    @(posedge i_mclk);
    cpu <= '0;
    #1;
  endtask

  task automatic bitw(input logic [2:0] i, input logic v);
    @(posedge i_mclk);
    cpu <= '{1'b1, 1'b0, 1'b1, i, v, DFA, 8'h00};
    @(posedge i_mclk);
    cpu <= '0;
    #1;
  endtask

  // Read data is sampled one full cycle after the taking edge, once it has settled.
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    cpu <= '{1'b0, 1'b1, 1'b0, 3'h0, 1'b0, a, 8'h00};
    @(posedge i_mclk);
    cpu <= '0;
    @(posedge i_mclk);
    #1;
    d = rdata;
  endtask

  task automatic setmode(input logic [7:0] m);
    wr(PKA, flash_gate_pkg::PROTECT_KEY);
    wr(PMA, m);
  endtask

  // The gate answers combinationally, so it is judged in the same cycle.
  task automatic gate(input logic [1:0] ar, input logic w, input logic ok);
    @(posedge i_mclk);
    req <= '{1'b1, w, flash_gate_pkg::flash_area_t'(ar)};
    #1;
    `CHK("grant", ok, grant)
    `CHK("reject", !ok, reject)
  endtask

  // Expected permission, worked out independently of the design.
  function automatic logic allow(input logic [1:0] ar, input logic w, input logic [1:0] m);
    if (ar == 2'h1) begin
      return !w || m == 2'h2;
    end
    return !w || m == 2'h1;
  endfunction

  // ==========================================================================
  // Scenarios.
  task automatic t_regs();
    rd(DFA, rv);
    `CHK("ctl reset", 8'h00, rv)
    `CHK("mode reset", 2'h0, mode)
    wr(DFA, 8'hFF);
    rd(DFA, rv);
    `CHK("ctl byte", 8'h01, rv)
    bitw(3'h0, 1'b0);
    rd(DFA, rv);
    `CHK("ctl bit clr", 8'h00, rv)
    bitw(3'h6, 1'b1);
    rd(DFA, rv);
    `CHK("ctl bit6", 8'h00, rv)
    bitw(3'h0, 1'b1);
    `CHK("enable", 1'b1, en)
    rd(20'hF0091, rv);
    `CHK("unmapped", 8'h00, rv)
    $display("test regs done");
  endtask

  task automatic t_enable();
    wr(DFA, 8'h00);
    gate(2'h1, 1'b0, 1'b0);
    gate(2'h2, 1'b0, 1'b1);
    gate(2'h0, 1'b0, 1'b1);
    wr(DFA, 8'h01);
    gate(2'h1, 1'b0, 1'b1);
    $display("test enable done");
  endtask

  task automatic t_seq();
    wr(PMA, 8'h01);
    rd(PMA, rv);
    `CHK("mode no key", 8'h04, rv)
    wr(PKA, flash_gate_pkg::PROTECT_KEY);
    wr(DFA, 8'h01);
    wr(PMA, 8'h01);
    `CHK("mode disarmed", 2'h0, mode)
    setmode(8'h03);
    `CHK("mode 11", 2'h0, mode)
    setmode(8'h01);
    rd(PMA, rv);
    `CHK("mode ok", 8'h01, rv)
    $display("test sequence done");
  endtask

  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      setmode(8'(m));
      `CHK("mode", 2'(m), mode)
      for (int a = 0; a < 3; a++) begin
        for (int w = 0; w < 2; w++) begin
          gate(2'(a), 1'(w), allow(2'(a), 1'(w), 2'(m)));
        end
      end
    end
    wr(DFA, 8'h00);
    gate(2'h1, 1'b1, 1'b0);
    $display("test modes done");
  endtask

  // ==========================================================================
  // Verdict and run control.
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The tests need under 100 cycles; the watchdog allows ample margin.
  initial begin
    repeat (3000) @(posedge i_mclk);
    n_mismatch++;
    results();
  end

  initial begin
    i_arst_n = 1'b0;
    cpu = '0;
    req = '0;
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    t_regs();
    t_enable();
    t_seq();
    t_modes();
    results();
  end
endmodule
